// ===== rasc_pkg.sv
package rasc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Widths and types
  localparam int ADDR_W = 8;
  typedef logic [ADDR_W-1:0] rasc_addr_t;
  typedef logic [9:0]        rasc_volt_t;
  typedef logic [13:0]       rasc_speed_t;
  typedef logic [7:0]        rasc_gain_t;
  typedef logic [15:0]       rasc_timer_t;
  typedef enum logic [1:0] {RASC_IDLE, RASC_RAISE, RASC_HOLD} rasc_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam rasc_addr_t OFS_MODE     = 8'h00;
  localparam rasc_addr_t OFS_LEVEL    = 8'h04;
  localparam rasc_addr_t OFS_LIMIT    = 8'h08;
  localparam rasc_addr_t OFS_VGAIN    = 8'h0c;
  localparam rasc_addr_t OFS_SGAIN    = 8'h10;
  localparam rasc_addr_t OFS_MAXSPD   = 8'h14;
  localparam rasc_addr_t OFS_RATED    = 8'h18;
  localparam rasc_addr_t OFS_EXTDISP  = 8'h1c;
  localparam rasc_addr_t OFS_OLTIMER  = 8'h20;
  localparam rasc_addr_t OFS_STATUS   = 8'h24;

  // Status field positions
  localparam int ST_ACTIVE    = 0;
  localparam int ST_OVERLOAD  = 1;
  localparam int ST_HOLD      = 2;
  localparam int ST_SPEED_LSB = 16;

  ////////////////////////////////////////////////////////////////////////////////
  // Mode codes of avoid_mode_select
  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_ALWAYS = 2'h1;
  localparam logic [1:0] MODE_CONST  = 2'h2;

  // Ranges and values after reset
  localparam rasc_volt_t  LEVEL_MIN      = 10'h12c;
  localparam rasc_volt_t  LEVEL_MAX      = 10'h320;
  localparam rasc_volt_t  LEVEL_RST_LOW  = 10'h190;
  localparam rasc_volt_t  LEVEL_RST_HIGH = 10'h30c;
  localparam rasc_speed_t LIMIT_RST      = 14'h0b4;
  localparam rasc_speed_t LIMIT_MAX_STD  = 14'h384;
  localparam rasc_speed_t LIMIT_MAX_BIG  = 14'h258;
  localparam rasc_speed_t LIMIT_NONE     = 14'h270f;
  localparam rasc_speed_t MAXSPD_RST     = 14'h0bb8;
  localparam rasc_speed_t RATED_RST      = 14'h0708;
  localparam rasc_gain_t  GAIN_RST       = 8'h64;
  localparam rasc_gain_t  GAIN_MAX       = 8'hc8;
  localparam logic [1:0]  MODE_RST       = 2'h0;
  localparam logic [7:0]  EXTDISP_RST    = 8'h00;
  localparam rasc_timer_t OLTIMER_RST    = 16'h0000;

  // Both gains are percent, so their product is scaled by 100 * 100
  localparam logic [25:0] GAIN_SCALE = 26'h2710;
  // 7.5 percent of rated speed as the ratio 3 / 40
  localparam logic [19:0] FLOOR_NUM  = 20'h3;
  localparam logic [19:0] FLOOR_DEN  = 20'h28;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing: compensation steps and overload timer count in 1 us ticks
  localparam int CLK_PERIOD_NS  = 10;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [6:0] TICK_LAST = 7'(TICK_CYCLES - 1);

endpackage

// ===== rasc_gain_if.sv
`timescale 1ns/1ps
// Carries the voltage excess and both gains to the increment calculator
interface rasc_gain_if;
  import rasc_pkg::*;
  rasc_volt_t  excess;
  rasc_gain_t  voltGain;
  rasc_gain_t  speedGain;
  rasc_speed_t increment;
  modport calc (input excess, input voltGain, input speedGain, output increment);
  modport user (output excess, output voltGain, output speedGain, input increment);
endinterface

// ===== rasc_gain_calc.sv
`timescale 1ns/1ps
module rasc_gain_calc (
  rasc_gain_if.calc gif
);
  import rasc_pkg::*;

  logic [25:0] product;
  logic [25:0] quotient;

  // Step grows with the overshoot, so the ramp follows the regeneration load
  assign product  = 26'(gif.excess) * 26'(gif.voltGain) * 26'(gif.speedGain);
  assign quotient = product / GAIN_SCALE;

  // Saturate rather than wrap, a wrapped step would drop the speed
  assign gif.increment = (quotient > 26'(14'h3fff)) ? 14'h3fff : quotient[13:0];
endmodule

// ===== rasc_regen_avoid.sv
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// How it works
// - Mode 0 off, 1 always on, 2 only at constant speed.
// - Avoidance starts when bus voltage reaches or exceeds the avoidance level.
// - Level accepts 300 to 800 V; resets to 400 or 780 by class.
// - Compensation limit resets to 180; range 0 to 900, or 600 on big units.
// - Accelerating or steady, compensation is capped at start speed plus limit.
// - Decelerating over the limit, hold limit until speed falls to half limit.
// - While avoiding, output speed never exceeds the maximum speed setting; idle passes the command unclamped.
// - Limit value 9999 removes the compensation cap.
// - Voltage gain 0 to 200 percent scales reaction; larger reacts faster.
// - Separate speed gain 0 to 200 percent also scales the compensation.
// - No avoidance at or below 7.5 percent of rated speed.
// - While acting, show overvoltage stall and drive the overload output.
// - While acting, stall prevention is active too.
// - Overload output waits for its own timer after avoidance starts.
// - Ramp during avoidance follows the regeneration load.
// - Settings other than extended display select accept writes only while it is zero.
module rasc_regen_avoid #(
  parameter bit HIGH_VOLT_CLASS = 1'b0,
  parameter bit LARGE_UNIT      = 1'b0
) (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire rasc_pkg::rasc_addr_t paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire rasc_pkg::rasc_volt_t  busVoltage,
  input  wire rasc_pkg::rasc_speed_t speedCmd,
  input  wire rasc_pkg::rasc_speed_t motorSpeed,
  input  wire logic               accelerating,
  input  wire logic               decelerating,
  output rasc_pkg::rasc_speed_t   speedCmdOut,
  output logic                    ovStallIndicate,
  output logic                    overloadStatusOut,
  output logic                    stallPrevent
);
  import rasc_pkg::*;

  localparam rasc_volt_t  LEVEL_RST = HIGH_VOLT_CLASS ? LEVEL_RST_HIGH : LEVEL_RST_LOW;
  localparam rasc_speed_t LIMIT_MAX = LARGE_UNIT ? LIMIT_MAX_BIG : LIMIT_MAX_STD;

  ////////////////////////////////////////////////////////////////////////////////
  // Settings
  logic [1:0]  avoidMode;
  rasc_volt_t  avoidLevel;
  rasc_speed_t compLimit;
  rasc_gain_t  voltGain;
  rasc_gain_t  speedGain;
  rasc_speed_t maxSpeed;
  rasc_speed_t ratedSpeed;
  logic [7:0]  extDisplay;
  rasc_timer_t overloadOutputTimer;
  logic [1:0]  next_avoidMode;
  rasc_volt_t  next_avoidLevel;
  rasc_speed_t next_compLimit;
  rasc_gain_t  next_voltGain;
  rasc_gain_t  next_speedGain;
  rasc_speed_t next_maxSpeed;
  rasc_speed_t next_ratedSpeed;
  logic [7:0]  next_extDisplay;
  rasc_timer_t next_overloadOutputTimer;

  // Bus answer
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        setupPhase;
  logic        wrCommit;
  logic        mapped;
  logic        refused;
  logic [31:0] readData;

  // Avoidance state
  rasc_state_t state;
  rasc_state_t next_state;
  rasc_speed_t comp;
  rasc_speed_t next_comp;
  rasc_speed_t baseSpeed;
  rasc_speed_t next_baseSpeed;
  rasc_speed_t next_speedCmdOut;
  logic [14:0] compSum;
  logic [14:0] boosted;
  logic        enabled;
  logic        speedOk;
  logic        overLevel;
  logic        trigger;
  logic        limitOn;
  logic        holdExit;

  // Tick and overload timer
  logic [6:0]  tickCount;
  logic [6:0]  next_tickCount;
  logic        tick;
  rasc_timer_t overloadCount;
  rasc_timer_t next_overloadCount;
  logic        next_ovStallIndicate;
  logic        next_overloadStatusOut;

  rasc_gain_if gif ();

  rasc_gain_calc u_gain (
    .gif (gif.calc)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode: answers one cycle after setup, so every access has no wait state
  assign setupPhase = psel & ~penable;
  assign wrCommit   = psel & penable & pready & pwrite & ~pslverr;

  always_comb begin
    mapped   = 1'b1;
    refused  = 1'b0;
    readData = 32'h0000_0000;
    case (paddr)
      OFS_MODE: begin
        readData = 32'(avoidMode);
        refused  = (pwdata > 32'(MODE_CONST));
      end
      OFS_LEVEL: begin
        readData = 32'(avoidLevel);
        refused  = (pwdata < 32'(LEVEL_MIN)) | (pwdata > 32'(LEVEL_MAX));
      end
      OFS_LIMIT: begin
        readData = 32'(compLimit);
        refused  = (pwdata > 32'(LIMIT_MAX)) & (pwdata != 32'(LIMIT_NONE));
      end
      OFS_VGAIN: begin
        readData = 32'(voltGain);
        refused  = (pwdata > 32'(GAIN_MAX));
      end
      OFS_SGAIN: begin
        readData = 32'(speedGain);
        refused  = (pwdata > 32'(GAIN_MAX));
      end
      OFS_MAXSPD: begin
        readData = 32'(maxSpeed);
        refused  = (pwdata > 32'(14'h3fff));
      end
      OFS_RATED: begin
        readData = 32'(ratedSpeed);
        refused  = (pwdata > 32'(14'h3fff)) | (pwdata == 32'h0000_0000);
      end
      OFS_EXTDISP: begin
        readData = 32'(extDisplay);
        refused  = (pwdata > 32'h0000_00ff);
      end
      OFS_OLTIMER: begin
        readData = 32'(overloadOutputTimer);
        refused  = (pwdata > 32'h0000_ffff);
      end
      OFS_STATUS: begin
        readData[ST_ACTIVE]                       = ovStallIndicate;
        readData[ST_OVERLOAD]                     = overloadStatusOut;
        readData[ST_HOLD]                         = (state == RASC_HOLD);
        readData[ST_SPEED_LSB +: $bits(rasc_speed_t)] = speedCmdOut;
        refused                                   = 1'b1; // Read only
      end
      default: mapped = 1'b0;
    endcase
    // Settings other than the extended display selection lock while it is nonzero
    if (paddr != OFS_EXTDISP && extDisplay != 8'h00) begin
      refused = 1'b1;
    end
  end

  // Answer registered so that bus outputs come straight from flops
  always_comb begin
    next_pready  = setupPhase;
    next_prdata  = (setupPhase & ~pwrite & mapped) ? readData : 32'h0000_0000;
    next_pslverr = setupPhase & (~mapped | (pwrite & refused));
  end

  // A refused or unmapped write leaves every setting untouched
  always_comb begin
    next_avoidMode  = avoidMode;
    next_avoidLevel = avoidLevel;
    next_compLimit  = compLimit;
    next_voltGain   = voltGain;
    next_speedGain  = speedGain;
    next_maxSpeed   = maxSpeed;
    next_ratedSpeed = ratedSpeed;
    next_extDisplay = extDisplay;
    next_overloadOutputTimer = overloadOutputTimer;
    if (wrCommit) begin
      case (paddr)
        OFS_MODE:    next_avoidMode  = pwdata[1:0];
        OFS_LEVEL:   next_avoidLevel = pwdata[9:0];
        OFS_LIMIT:   next_compLimit  = pwdata[13:0];
        OFS_VGAIN:   next_voltGain   = pwdata[7:0];
        OFS_SGAIN:   next_speedGain  = pwdata[7:0];
        OFS_MAXSPD:  next_maxSpeed   = pwdata[13:0];
        OFS_RATED:   next_ratedSpeed = pwdata[13:0];
        OFS_EXTDISP: next_extDisplay = pwdata[7:0];
        OFS_OLTIMER: next_overloadOutputTimer = pwdata[15:0];
        default:     next_overloadOutputTimer = overloadOutputTimer;
      endcase
    end
  end

  // Register file and bus answer
  always_ff @(posedge clk) begin
    if (reset) begin
      avoidMode  <= MODE_RST;
      avoidLevel <= LEVEL_RST;
      compLimit  <= LIMIT_RST;
      voltGain   <= GAIN_RST;
      speedGain  <= GAIN_RST;
      maxSpeed   <= MAXSPD_RST;
      ratedSpeed <= RATED_RST;
      extDisplay <= EXTDISP_RST;
      overloadOutputTimer <= OLTIMER_RST;
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
    end else begin
      avoidMode  <= next_avoidMode;
      avoidLevel <= next_avoidLevel;
      compLimit  <= next_compLimit;
      voltGain   <= next_voltGain;
      speedGain  <= next_speedGain;
      maxSpeed   <= next_maxSpeed;
      ratedSpeed <= next_ratedSpeed;
      extDisplay <= next_extDisplay;
      overloadOutputTimer <= next_overloadOutputTimer;
      prdata     <= next_prdata;
      pready     <= next_pready;
      pslverr    <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Qualifiers; mode 3 is never stored, so it cannot enable anything
  assign enabled   = (avoidMode == MODE_ALWAYS) |
                     ((avoidMode == MODE_CONST) & ~accelerating & ~decelerating);
  assign speedOk   = (20'(motorSpeed) * FLOOR_DEN) > (20'(ratedSpeed) * FLOOR_NUM);
  assign overLevel = (busVoltage >= avoidLevel);
  assign trigger   = enabled & speedOk & overLevel;
  assign limitOn   = (compLimit != LIMIT_NONE);
  assign holdExit  = ~enabled | ~speedOk | (motorSpeed <= {1'b0, compLimit[13:1]});

  // Increment path through the gain calculator
  assign gif.excess    = overLevel ? (busVoltage - avoidLevel) : 10'h000;
  assign gif.voltGain  = voltGain;
  assign gif.speedGain = speedGain;
  assign compSum       = {1'b0, comp} + {1'b0, gif.increment};
  assign boosted       = {1'b0, baseSpeed} + {1'b0, comp};

  // Steps once per tick, so gains set the ramp rather than the clock rate
  always_comb begin
    next_state     = state;
    next_comp      = comp;
    next_baseSpeed = baseSpeed;
    unique case (state)
      RASC_IDLE: begin
        if (trigger) begin
          next_state     = RASC_RAISE;
          next_baseSpeed = speedCmd;
          next_comp      = 14'h0000;
        end
      end
      RASC_RAISE: begin
        if (!trigger) begin
          next_state = RASC_IDLE;
          next_comp  = 14'h0000;
        end else if (tick) begin
          if (limitOn && compSum > {1'b0, compLimit}) begin
            next_comp = compLimit;
            if (decelerating) begin
              next_state = RASC_HOLD;
            end
          end else begin
            next_comp = compSum[14] ? 14'h3fff : compSum[13:0];
          end
        end
      end
      RASC_HOLD: begin
        if (holdExit) begin
          next_state = RASC_IDLE;
          next_comp  = 14'h0000;
        end
      end
    endcase
  end

  // Idle passes the ordinary command straight through
  always_comb begin
    if (state == RASC_IDLE) begin
      next_speedCmdOut = speedCmd;
    end else if (boosted > {1'b0, maxSpeed}) begin
      next_speedCmdOut = maxSpeed;
    end else begin
      next_speedCmdOut = boosted[13:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state       <= RASC_IDLE;
      comp        <= 14'h0000;
      baseSpeed   <= 14'h0000;
      speedCmdOut <= 14'h0000;
    end else begin
      state       <= next_state;
      comp        <= next_comp;
      baseSpeed   <= next_baseSpeed;
      speedCmdOut <= next_speedCmdOut;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Microsecond tick and overload delay
  assign tick = (tickCount == TICK_LAST);

  always_comb begin
    next_tickCount         = tick ? 7'h00 : tickCount + 7'h01;
    next_overloadCount     = overloadCount;
    next_ovStallIndicate   = (state != RASC_IDLE);
    next_overloadStatusOut = 1'b0;
    if (state == RASC_IDLE) begin
      next_overloadCount = 16'h0000;
    end else begin
      // Output only after the timer; with a zero timer it rises together with the stall indication
      next_overloadStatusOut = (overloadCount >= overloadOutputTimer);
      if (tick && overloadCount != 16'hffff) begin
        next_overloadCount = overloadCount + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tickCount         <= 7'h00;
      overloadCount     <= 16'h0000;
      ovStallIndicate   <= 1'b0;
      overloadStatusOut <= 1'b0;
      stallPrevent      <= 1'b0;
    end else begin
      tickCount         <= next_tickCount;
      overloadCount     <= next_overloadCount;
      ovStallIndicate   <= next_ovStallIndicate;
      overloadStatusOut <= next_overloadStatusOut;
      stallPrevent      <= next_ovStallIndicate;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_mode_off;
    (avoidMode == MODE_OFF) |=> (state == RASC_IDLE);
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("mode 0 left avoidance on");

  property p_start;
    (state == RASC_IDLE && trigger) |=> (state == RASC_RAISE && comp == 14'h0000);
  endproperty
  a_start: assert property (p_start) else $error("avoidance did not start");

  property p_cap;
    (state != RASC_IDLE && limitOn) |-> (comp <= compLimit || $changed(compLimit));
  endproperty
  a_cap: assert property (p_cap) else $error("compensation above limit");

  property p_hold;
    (state == RASC_HOLD && !holdExit) |=> (state == RASC_HOLD && comp == $past(comp));
  endproperty
  a_hold: assert property (p_hold) else $error("hold released early");

  property p_max;
    (state != RASC_IDLE) |=> (speedCmdOut <= $past(maxSpeed));
  endproperty
  a_max: assert property (p_max) else $error("speed above maximum");

  property p_floor;
    !speedOk |=> (state == RASC_IDLE) ##1 !ovStallIndicate;
  endproperty
  a_floor: assert property (p_floor) else $error("active at low speed");

  property p_stall;
    (state != RASC_IDLE) |=> (stallPrevent && ovStallIndicate);
  endproperty
  a_stall: assert property (p_stall) else $error("stall prevention not active");

  property p_overload_delay;
    ($rose(ovStallIndicate) && overloadOutputTimer != 16'h0000) |-> !overloadStatusOut;
  endproperty
  a_overload_delay: assert property (p_overload_delay) else $error("overload output not delayed");

  property p_lock;
    (wrCommit && paddr == OFS_LEVEL) |-> (extDisplay == 8'h00);
  endproperty
  a_lock: assert property (p_lock) else $error("write taken while locked");

  property p_withdraw;
    (state == RASC_RAISE && !overLevel) |=> (state == RASC_IDLE && comp == 14'h0000);
  endproperty
  a_withdraw: assert property (p_withdraw) else $error("compensation not withdrawn");

endmodule

// ===== rasc_drive_model.sv
`timescale 1ns/1ps
// Bus voltage sensing and speed command path on the far side of the core
module rasc_drive_model (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire rasc_pkg::rasc_volt_t  tgtBus,
  input  wire rasc_pkg::rasc_speed_t tgtSpeed,
  input  wire rasc_pkg::rasc_speed_t tgtMotor,
  input  wire logic [1:0]            tgtRamp,
  output rasc_pkg::rasc_volt_t       busVoltage,
  output rasc_pkg::rasc_speed_t      speedCmd,
  output rasc_pkg::rasc_speed_t      motorSpeed,
  output logic                       accelerating,
  output logic                       decelerating
);
  import rasc_pkg::*;
  logic next_accel;
  logic next_decel;
  // A real ramp is never speeding up and slowing down at once
  always_comb begin
    next_accel = tgtRamp[1];
    next_decel = tgtRamp[0] & ~tgtRamp[1];
  end
  // One sample of sensor lag on every measured value
  always_ff @(posedge clk) begin
    busVoltage   <= reset ? '0 : tgtBus;
    speedCmd     <= reset ? '0 : tgtSpeed;
    motorSpeed   <= reset ? '0 : tgtMotor;
    accelerating <= reset ? 1'b0 : next_accel;
    decelerating <= reset ? 1'b0 : next_decel;
  end
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  import rasc_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  rasc_addr_t  paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  rasc_volt_t  tgtBus = '0;
  rasc_speed_t tgtSpeed = 14'h3e8;
  rasc_speed_t tgtMotor = '0;
  logic [1:0]  tgtRamp = '0;
  rasc_volt_t  busVoltage;
  rasc_speed_t speedCmd;
  rasc_speed_t motorSpeed;
  logic        accelerating;
  logic        decelerating;
  rasc_speed_t speedCmdOut;
  logic        ovStallIndicate;
  logic        overloadStatusOut;
  logic        stallPrevent;
  logic [31:0] rdv;
  logic        erv;
  int          bad_count = 0;
  int          check_count = 0;

  // 100 MHz
  always #5 clk = ~clk;

  rasc_regen_avoid dut_u (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .busVoltage, .speedCmd, .motorSpeed, .accelerating, .decelerating,
    .speedCmdOut, .ovStallIndicate, .overloadStatusOut, .stallPrevent);
  rasc_drive_model drv_u (.clk, .reset, .tgtBus, .tgtSpeed, .tgtMotor, .tgtRamp,
    .busVoltage, .speedCmd, .motorSpeed, .accelerating, .decelerating);

  ////////////////////////////////////////
  // Verdict, comparison and bus tasks
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Setup then access; request held until pready is sampled high
  task automatic apb(input rasc_addr_t a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad_count++;
      stop_test();
    end
  endtask
  task automatic wr(input rasc_addr_t a, input logic [31:0] d, input logic e);
    apb(a, 1'b1, d);
    chk(32'(erv), 32'(e));
  endtask
  task automatic rd(input rasc_addr_t a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(rdv, e);
  endtask
  // Far-side conditions change, then n cycles pass
  task automatic link(input rasc_volt_t b, input rasc_speed_t m, input logic [1:0] r,
                      input int n);
    tgtBus <= b;
    tgtMotor <= m;
    tgtRamp <= r;
    repeat (n) @(posedge clk);
  endtask
  // Bounded wait for the output to leave a value
  task automatic wait_out(input rasc_speed_t v);
    int n;
    n = 0;
    while (speedCmdOut === v && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) begin
      bad_count++;
      stop_test();
    end
  endtask

  ////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd(OFS_MODE, 32'h0);
    rd(OFS_LEVEL, 32'h190);
    rd(OFS_LIMIT, 32'hb4);
    rd(OFS_VGAIN, 32'h64);
    rd(OFS_SGAIN, 32'h64);
    rd(OFS_MAXSPD, 32'hbb8);
    wr(OFS_LEVEL, 32'h12b, 1'b1);
    wr(OFS_LEVEL, 32'h321, 1'b1);
    wr(OFS_LEVEL, 32'h320, 1'b0);
    rd(OFS_LEVEL, 32'h320);
    wr(OFS_LIMIT, 32'h385, 1'b1);
    wr(OFS_VGAIN, 32'hc9, 1'b1);
    wr(OFS_SGAIN, 32'hc9, 1'b1);
    wr(OFS_MODE, 32'h3, 1'b1);
    wr(OFS_STATUS, 32'h1, 1'b1);
    rd(8'h28, 32'h0);
    chk(32'(erv), 32'h1);
    wr(OFS_EXTDISP, 32'h1, 1'b0);
    wr(OFS_LEVEL, 32'h190, 1'b1);
    wr(OFS_EXTDISP, 32'h0, 1'b0);
    wr(OFS_LEVEL, 32'h190, 1'b0);
    // Avoidance off: no reaction to a high bus; normal bus stays under the level
    link(10'h1f4, 14'h3e8, 2'b00, 6);
    chk(32'(ovStallIndicate), 32'h0);
    wr(OFS_MODE, 32'h1, 1'b0);
    link(10'h18f, 14'h3e8, 2'b00, 6);
    chk(32'(ovStallIndicate), 32'h0);
    link(10'h1f4, 14'h087, 2'b00, 6);
    chk(32'(ovStallIndicate), 32'h0);
    link(10'h190, 14'h088, 2'b00, 6);
    chk(32'(ovStallIndicate), 32'h1);
    chk(32'(stallPrevent), 32'h1);
    chk(32'(overloadStatusOut), 32'h1);
    chk(32'(speedCmdOut), 32'h3e8);
    link(10'h1f4, 14'h3e8, 2'b00, 1);
    wait_out(14'h3e8);
    chk(32'(speedCmdOut), 32'h44c);
    link(10'h1f4, 14'h3e8, 2'b00, 400);
    chk(32'(speedCmdOut), 32'h49c);
    link(10'h137, 14'h3e8, 2'b00, 6);
    chk(32'(ovStallIndicate), 32'h0);
    chk(32'(speedCmdOut), 32'h3e8);
    // Constant-speed mode ignores a ramping motor, accelerating or decelerating
    wr(OFS_MODE, 32'h2, 1'b0);
    link(10'h1f4, 14'h3e8, 2'b10, 6);
    chk(32'(ovStallIndicate), 32'h0);
    link(10'h1f4, 14'h3e8, 2'b01, 6);
    chk(32'(ovStallIndicate), 32'h0);
    link(10'h1f4, 14'h3e8, 2'b00, 6);
    chk(32'(ovStallIndicate), 32'h1);
    link(10'h137, 14'h3e8, 2'b00, 6);
    // Limit held in deceleration until speed reaches half the limit
    wr(OFS_MODE, 32'h1, 1'b0);
    wr(OFS_LIMIT, 32'h258, 1'b0);
    link(10'h1f4, 14'h3e8, 2'b01, 900);
    chk(32'(speedCmdOut), 32'h640);
    link(10'h137, 14'h3e8, 2'b01, 20);
    chk(32'(speedCmdOut), 32'h640);
    rd(OFS_STATUS, 32'h0640_0007);
    link(10'h137, 14'h12c, 2'b01, 6);
    chk(32'(speedCmdOut), 32'h3e8);
    // Overload output waits for its own timer, 20 us here
    wr(OFS_OLTIMER, 32'h14, 1'b0);
    link(10'h1f4, 14'h3e8, 2'b00, 6);
    chk(32'(ovStallIndicate), 32'h1);
    chk(32'(overloadStatusOut), 32'h0);
    link(10'h1f4, 14'h3e8, 2'b00, 2300);
    chk(32'(overloadStatusOut), 32'h1);
    link(10'h137, 14'h3e8, 2'b00, 6);
    // Unlimited compensation with double voltage gain runs into the maximum speed
    wr(OFS_LIMIT, 32'h270f, 1'b0);
    wr(OFS_VGAIN, 32'hc8, 1'b0);
    link(10'h1f4, 14'h3e8, 2'b00, 1);
    wait_out(14'h3e8);
    chk(32'(speedCmdOut), 32'h4b0);
    link(10'h1f4, 14'h3e8, 2'b00, 2500);
    chk(32'(speedCmdOut), 32'hbb8);
    stop_test();
  end
endmodule
